// File: dv/etr_top_tb.sv
// self-checking bench for the egress tag control and pacing block
`timescale 1ns/100ps
`default_nettype none
`include "etr_regs.svh"

// =====================================================
// compare macro
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module etr_top_tb;
  // =====================================================
  // signals
  logic                          core_clk_i    = 1'b0;
  logic                          rst_i         = 1'b1;
  logic [15:0]                   s_axi_awaddr  = 16'h0000;
  logic                          s_axi_awvalid = 1'b0;
  logic                          s_axi_awready;
  logic [31:0]                   s_axi_wdata   = 32'h00000000;
  logic [3:0]                    s_axi_wstrb   = 4'h0;
  logic                          s_axi_wvalid  = 1'b0;
  logic                          s_axi_wready;
  logic [1:0]                    s_axi_bresp;
  logic                          s_axi_bvalid;
  logic                          s_axi_bready  = 1'b0;
  logic [15:0]                   s_axi_araddr  = 16'h0000;
  logic                          s_axi_arvalid = 1'b0;
  logic                          s_axi_arready;
  logic [31:0]                   s_axi_rdata;
  logic [1:0]                    s_axi_rresp;
  logic                          s_axi_rvalid;
  logic                          s_axi_rready  = 1'b0;
  logic                          frm_valid_i   = 1'b0;
  etr_pkg::etr_frm_s             frm_i         = '0;
  logic                          act_valid_o;
  etr_pkg::etr_act_s             act_o;
  etr_pkg::etr_port_ctl_s [2:0]  port_ctl_o;
  logic [7:0]                    byte_send_i   = 8'h00;
  logic [7:0]                    byte_ready_o;
  int                            bad_count     = 0;
  int                            total_checks  = 0;
  int                            cyc           = 0;

  // frame cases: tag control word, frame {port,kind,untag}, action {strip,ins,vid,prio,src}
  logic [31:0] tc_ctl [16] = '{32'h00000000, 32'h00000000, 32'h00010000, 32'h00010000,
    32'h00030000, 32'h00220000, 32'h00220000, 32'h00160000, 32'h00120000, 32'h000e0000,
    32'h00160000, 32'h00000100, 32'h00000003, 32'h00030303, 32'h000a0000, 32'h00020000};
  logic [4:0]  tc_frm [16] = '{5'b10110, 5'b10100, 5'b10100, 5'b10110, 5'b10000, 5'b10000,
    5'b10001, 5'b10100, 5'b10100, 5'b10100, 5'b10101, 5'b01100, 5'b00000, 5'b11100,
    5'b10010, 5'b10110};
  logic [4:0]  tc_act [16] = '{5'b10000, 5'b00000, 5'b10000, 5'b10000, 5'b00001, 5'b01000,
    5'b00000, 5'b00100, 5'b00000, 5'b00010, 5'b10000, 5'b10000, 5'b00001, 5'b00000,
    5'b00110, 5'b10000};

  // =====================================================
  // design under test
  etr_top i_etr_top (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .frm_valid_i   (frm_valid_i),
    .frm_i         (frm_i),
    .act_valid_o   (act_valid_o),
    .act_o         (act_o),
    .port_ctl_o    (port_ctl_o),
    .byte_send_i   (byte_send_i),
    .byte_ready_o  (byte_ready_o)
  );

  // 10 mhz clock
  always #50 core_clk_i = ~core_clk_i;

  // hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // =====================================================
  // bus tasks: flags sampled mid-cycle, drives land just after the edge
  function automatic logic [15:0] ba(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] ex_resp);
    logic ta;
    logic tw;
    logic tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!tb) begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge core_clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    `CHK("bresp", ex_resp, r)
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] ex, input logic [1:0] ex_resp);
    logic ta;
    logic tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!tr) begin
      @(negedge core_clk_i);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge core_clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    `CHK("rdata", ex, d)
    `CHK("rresp", ex_resp, r)
  endtask : rd

  // one frame descriptor, action checked in the cycle after it is taken
  task automatic frame(input logic [4:0] f, input logic [4:0] ex);
    @(posedge core_clk_i);
    frm_valid_i <= 1'b1;
    frm_i       <= f;
    @(posedge core_clk_i);
    frm_valid_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK("act_valid", 1'b1, act_valid_o)
    `CHK("act", ex, act_o)
  endtask : frame

  // one byte granted on queue q, ready expected back gap cycles later
  task automatic pace(input int q, input int gap);
    @(posedge core_clk_i);
    byte_send_i[q] <= 1'b1;
    @(negedge core_clk_i);
    `CHK("ready before grant", 1'b1, byte_ready_o[q])
    @(posedge core_clk_i);
    byte_send_i[q] <= 1'b0;
    for (int k = 1; k <= gap; k++) begin
      @(negedge core_clk_i);
      `CHK("ready after grant", (k == gap), byte_ready_o[q])
    end
  endtask : pace

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // =====================================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < 5; i++) begin
      rd(ba(`ETR_IDX_TAGCTL + 14'(i)), 32'h00000000, `ETR_RESP_OKAY); // reset zero
    end
    wr(ba(`ETR_IDX_TAGCTL), 32'hffffffff, 4'hf, `ETR_RESP_OKAY); // reserved dropped
    rd(ba(`ETR_IDX_TAGCTL), 32'h003f3f3f, `ETR_RESP_OKAY); // field bits
    wr(ba(`ETR_IDX_TAGCTL), 32'h00000000, 4'h2, `ETR_RESP_OKAY); // lane one write
    rd(ba(`ETR_IDX_TAGCTL), 32'h003f003f, `ETR_RESP_OKAY); // only lane one cleared
    `CHK("port0 ctl", 6'h3f, port_ctl_o[0]) // port zero fields
    `CHK("port1 ctl", 6'h00, port_ctl_o[1]) // port one fields
    `CHK("port2 ctl", 6'h3f, port_ctl_o[2]) // port two fields
    for (int i = 1; i <= `ETR_NUM_RATE; i++) begin
      wr(ba(`ETR_IDX_TAGCTL + 14'(i)), 32'hffffffff, 4'hf, `ETR_RESP_OKAY); // all ones
      rd(ba(`ETR_IDX_TAGCTL + 14'(i)), 32'h03ffffff, `ETR_RESP_OKAY); // rate mask
      wr(ba(`ETR_IDX_TAGCTL + 14'(i)), 32'h00000000, 4'hf, `ETR_RESP_OKAY); // clear word
    end
    wr(16'h7ffc, 32'h12345678, 4'hf, `ETR_RESP_SLVERR); // unmapped write
    rd(16'h7ffc, 32'h00000000, `ETR_RESP_SLVERR); // unmapped read
    // tag action per egress type and enable mix
    for (int i = 0; i < 16; i++) begin
      wr(ba(`ETR_IDX_TAGCTL), tc_ctl[i], 4'hf, `ETR_RESP_OKAY); // type and enables
      frame(tc_frm[i], tc_act[i]);
    end
    // pacing: queue 0 of port 0, queue 1 of port 1, queue 2 of port 0 at reset value
    wr(ba(`ETR_IDX_P0Q01), 32'h00000009, 4'hf, `ETR_RESP_OKAY); // cost nine
    wr(ba(`ETR_IDX_P1Q01), 32'h00030000, 4'hf, `ETR_RESP_OKAY); // port one upper field
    rd(ba(`ETR_IDX_P1Q01), 32'h00030000, `ETR_RESP_OKAY); // independent fields
    pace(0, 2); // cost nine gives two cycles
    pace(0, 2); // second grant right after ready returns
    pace(5, 5); // upper field cost 24
    pace(2, 1); // zero cost at full rate
    tally_and_finish();
  end

endmodule : etr_top_tb
`default_nettype wire

// File: rtl/etr_pacer.sv
// one egress queue byte pacer
`timescale 1ns/100ps
`default_nettype none
`include "etr_regs.svh"

module etr_pacer (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`ETR_RATE_W-1:0] cost_i,
  input  wire logic                   send_i,
  output logic                        ready_o
);

  localparam logic [`ETR_WAIT_W-1:0] UNITS = `ETR_WAIT_W'(`ETR_UNITS_PER_CLK);

  logic [`ETR_WAIT_W-1:0] wait_ff;
  logic [`ETR_WAIT_W-1:0] nxt_wait;
  logic [`ETR_WAIT_W-1:0] base;
  logic                   rdy_ff;
  logic                   nxt_rdy;
  logic                   grant;

  // =====================================================
  // time left before the next byte, in 20 ns units
  // interval of cost plus one units
  always_comb begin
    grant    = send_i & rdy_ff;
    base     = grant ? (`ETR_WAIT_W'(cost_i) + 1'b1) : wait_ff;
    nxt_wait = (base > UNITS) ? (base - UNITS) : '0;
    nxt_rdy  = (nxt_wait == '0);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_ff <= '0;
      rdy_ff  <= 1'b0;
    end else begin
      wait_ff <= nxt_wait;
      rdy_ff  <= nxt_rdy;
    end
  end

  assign ready_o = rdy_ff;

  // =====================================================
  // helper: cycles since last grant and its cost
  logic [`ETR_WAIT_W-1:0] since_ff;
  logic [`ETR_WAIT_W-1:0] cost_q_ff;
  logic                   seen_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      since_ff  <= '0;
      cost_q_ff <= '0;
      seen_ff   <= 1'b0;
    end else begin
      if (grant) begin
        since_ff  <= `ETR_WAIT_W'(1);
        cost_q_ff <= `ETR_WAIT_W'(cost_i) + 1'b1;
        seen_ff   <= 1'b1;
      end else if (since_ff != '1) begin
        since_ff  <= since_ff + 1'b1;
      end
    end
  end

  chk_pace_gap_min: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (grant && seen_ff) |-> (17'(since_ff) * 17'(UNITS) >= 17'(cost_q_ff)))
    else $error("byte sent before its pacing interval");

  chk_pace_not_late: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ($rose(rdy_ff) && seen_ff && since_ff != '1)
      |-> (17'(since_ff - 1'b1) * 17'(UNITS) < 17'(cost_q_ff)))
    else $error("pacer ready later than needed");

endmodule : etr_pacer
`default_nettype wire

// File: rtl/etr_pkg.sv
// types shared by the egress tag and pacing block
package etr_pkg;

  // =====================================================
  // egress port type
  typedef enum logic [1:0] {
    ETR_PASS      = 2'b00,
    ETR_STRIP_ALL = 2'b01,
    ETR_MIXED     = 2'b10,
    ETR_SRC_TAG   = 2'b11
  } etr_type_e;

  // frame tag kind as seen at egress
  typedef enum logic [1:0] {
    ETR_UNTAGGED  = 2'b00,
    ETR_PRIO_TAG  = 2'b01,
    ETR_REG_TAG   = 2'b10,
    ETR_HOST_TAG  = 2'b11
  } etr_kind_e;

  // per-port control, bit order matches the register
  typedef struct packed {
    logic      insert_enable;
    logic      vid_replace_enable;
    logic      prio_replace_enable;
    logic      tag_change_enable;
    etr_type_e egress_type;
  } etr_port_ctl_s;

  typedef struct packed {
    logic [1:0] port;
    etr_kind_e  kind;
    logic       untag;
  } etr_frm_s;

  typedef struct packed {
    logic strip;
    logic insert;
    logic vid_new;
    logic prio_new;
    logic src_tag;
  } etr_act_s;

endpackage : etr_pkg

// File: rtl/etr_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef ETR_REGS_SVH
`define ETR_REGS_SVH

// =====================================================
// register indices (byte address is four times the index)
`define ETR_IDX_TAGCTL     14'h1c0c
`define ETR_IDX_P0Q01      14'h1c0d
`define ETR_IDX_P0Q23      14'h1c0e
`define ETR_IDX_P1Q01      14'h1c0f
`define ETR_IDX_P1Q23      14'h1c10
`define ETR_NUM_RATE       4
`define ETR_ADDR_W         16

// =====================================================
// field layout
`define ETR_PORT_STRIDE    8
`define ETR_PORT_CTL_W     6
`define ETR_TAGCTL_MASK    32'h003f3f3f
`define ETR_RATE_MASK      32'h03ffffff
`define ETR_RATE_W         13
`define ETR_RATE_HI_LSB    13
`define ETR_TAGCTL_RST     32'h00000000
`define ETR_RATE_RST       32'h00000000

// =====================================================
// pacing time base
`define ETR_STEP_NS        20
`define ETR_CLK_NS         100
`define ETR_UNITS_PER_CLK  (`ETR_CLK_NS / `ETR_STEP_NS)
`define ETR_WAIT_W         14

// =====================================================
// bus answers
`define ETR_RESP_OKAY      2'h0
`define ETR_RESP_SLVERR    2'h2

`endif

// File: rtl/etr_top.sv
// egress tag control and per-queue egress pacing with an axi4-lite register bank
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "etr_regs.svh"

module etr_top (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic [`ETR_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [`ETR_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         frm_valid_i,
  input  wire etr_pkg::etr_frm_s            frm_i,
  output logic                              act_valid_o,
  output etr_pkg::etr_act_s                 act_o,
  output etr_pkg::etr_port_ctl_s [2:0]      port_ctl_o,
  input  wire logic [7:0]                   byte_send_i,
  output logic [7:0]                        byte_ready_o
);

  // =====================================================
  // register storage
  logic [31:0]             tagctl_ff;
  logic [31:0]             nxt_tagctl;
  logic [31:0]             rate_ff     [`ETR_NUM_RATE];
  logic [31:0]             nxt_rate    [`ETR_NUM_RATE];
  logic                    aw_hold_ff, nxt_aw_hold;
  logic                    w_hold_ff, nxt_w_hold;
  logic [13:0]             aw_idx_ff, nxt_aw_idx;
  logic [31:0]             wdata_ff, nxt_wdata;
  logic [3:0]              wstrb_ff, nxt_wstrb;
  logic                    awready_ff, nxt_awready;
  logic                    wready_ff, nxt_wready;
  logic                    bvalid_ff, nxt_bvalid;
  logic [1:0]              bresp_ff, nxt_bresp;
  logic                    arready_ff, nxt_arready;
  logic                    rvalid_ff, nxt_rvalid;
  logic [31:0]             rdata_ff, nxt_rdata;
  logic [1:0]              rresp_ff, nxt_rresp;
  logic [31:0]             bytemask;
  logic                    do_wr;
  logic [13:0]             ar_idx;

  // read mux: unmapped reads answer zero
  function automatic logic [32:0] etr_read(input logic [13:0] idx, input logic [31:0] tc,
                                           input logic [31:0] r0, input logic [31:0] r1,
                                           input logic [31:0] r2, input logic [31:0] r3);
    logic [32:0] res;
    res = '0;
    case (idx)
      `ETR_IDX_TAGCTL: res = {1'b1, tc & `ETR_TAGCTL_MASK};
      `ETR_IDX_P0Q01:  res = {1'b1, r0 & `ETR_RATE_MASK};
      `ETR_IDX_P0Q23:  res = {1'b1, r1 & `ETR_RATE_MASK};
      `ETR_IDX_P1Q01:  res = {1'b1, r2 & `ETR_RATE_MASK};
      `ETR_IDX_P1Q23:  res = {1'b1, r3 & `ETR_RATE_MASK};
      default:         res = '0;
    endcase
    return res;
  endfunction : etr_read

  // =====================================================
  // axi4-lite write and read channels, register updates
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_tagctl  = tagctl_ff;
    nxt_rate    = rate_ff;
    ar_idx      = s_axi_araddr[`ETR_ADDR_W-1:2];
    for (int b = 0; b < 4; b++) begin
      bytemask[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
    // address and data taken in either order
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_idx  = s_axi_awaddr[`ETR_ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = `ETR_RESP_SLVERR;
      if (aw_idx_ff == `ETR_IDX_TAGCTL) begin
        nxt_tagctl = ((tagctl_ff & ~bytemask) | (wdata_ff & bytemask)) & `ETR_TAGCTL_MASK;
        nxt_bresp  = `ETR_RESP_OKAY;
      end
      // four rate words, two per port
      for (int i = 0; i < `ETR_NUM_RATE; i++) begin
        if (aw_idx_ff == `ETR_IDX_P0Q01 + 14'(i)) begin
          nxt_rate[i] = ((rate_ff[i] & ~bytemask) | (wdata_ff & bytemask)) & `ETR_RATE_MASK;
          nxt_bresp   = `ETR_RESP_OKAY;
        end
      end
    end
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready  = !nxt_w_hold && !nxt_bvalid;
    // read: one outstanding, answer next cycle
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      {nxt_rresp[1], nxt_rdata} = etr_read(ar_idx, tagctl_ff, rate_ff[0], rate_ff[1],
                                           rate_ff[2], rate_ff[3]);
      nxt_rresp[1] = !nxt_rresp[1];
      nxt_rresp[0] = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tagctl_ff  <= `ETR_TAGCTL_RST;
      for (int i = 0; i < `ETR_NUM_RATE; i++) begin
        rate_ff[i] <= `ETR_RATE_RST;
      end
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_idx_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= '0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= '0;
    end else begin
      tagctl_ff  <= nxt_tagctl;
      rate_ff    <= nxt_rate;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      aw_idx_ff  <= nxt_aw_idx;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // =====================================================
  // per-port control views of the tagging register
  // port 2 block at bits 21:16
  // port 1 block at bits 13:8
  // port 0 block at bits 5:0
  genvar gp;
  for (gp = 0; gp < 3; gp++) begin : g_port
    assign port_ctl_o[gp] = etr_pkg::etr_port_ctl_s'(
      tagctl_ff[gp*`ETR_PORT_STRIDE +: `ETR_PORT_CTL_W]);
  end

  // =====================================================
  // egress tag action for one frame
  etr_pkg::etr_act_s      act_ff, nxt_act;
  logic                   act_valid_ff, nxt_act_valid;
  etr_pkg::etr_port_ctl_s pc;

  always_comb begin
    nxt_act       = '0;
    nxt_act_valid = frm_valid_i;
    pc            = (frm_i.port == 2'h3) ? '0 : port_ctl_o[frm_i.port];
    case (pc.egress_type)
      // only the host source tag is removed
      etr_pkg::ETR_PASS: nxt_act.strip = (frm_i.kind == etr_pkg::ETR_HOST_TAG);
      etr_pkg::ETR_STRIP_ALL: nxt_act.strip = (frm_i.kind != etr_pkg::ETR_UNTAGGED);
      etr_pkg::ETR_MIXED: begin
        case (frm_i.kind)
          // default tag when insert is enabled and vlan is not untagged
          etr_pkg::ETR_UNTAGGED: nxt_act.insert = pc.insert_enable && !frm_i.untag;
          etr_pkg::ETR_PRIO_TAG: begin
            nxt_act.strip    = frm_i.untag;
            nxt_act.vid_new  = !frm_i.untag;
            nxt_act.prio_new = !frm_i.untag && pc.prio_replace_enable;
          end
          etr_pkg::ETR_REG_TAG: begin
            nxt_act.strip    = frm_i.untag;
            nxt_act.vid_new  = !frm_i.untag && pc.vid_replace_enable && pc.tag_change_enable;
            nxt_act.prio_new = !frm_i.untag && pc.prio_replace_enable && pc.tag_change_enable;
          end
          default: nxt_act.strip = 1'b1;
        endcase
      end
      etr_pkg::ETR_SRC_TAG: nxt_act.src_tag = 1'b1;
      default: nxt_act = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act_ff       <= '0;
      act_valid_ff <= 1'b0;
    end else begin
      act_ff       <= nxt_act;
      act_valid_ff <= nxt_act_valid;
    end
  end

  assign act_o       = act_ff;
  assign act_valid_o = act_valid_ff;

  // =====================================================
  // eight queue pacers, even queue in the low field
  // low field even queue, high field odd
  genvar gq;
  for (gq = 0; gq < 8; gq++) begin : g_pace
    etr_pacer u_pacer (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cost_i     (rate_ff[gq/2][(gq%2)*`ETR_RATE_HI_LSB +: `ETR_RATE_W]),
      .send_i     (byte_send_i[gq]),
      .ready_o    (byte_ready_o[gq])
    );
  end

  // =====================================================
  // checks
  chk_reset_clear: assert property (
    @(posedge core_clk_i) rst_i |=> (tagctl_ff == '0 && rate_ff[0] == '0))
    else $error("fields not zero after reset");

  chk_reserved_zero: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    s_axi_rvalid |-> (s_axi_rdata[31:26] == '0 && (tagctl_ff & ~`ETR_TAGCTL_MASK) == '0))
    else $error("reserved bits not zero");

  chk_pass_type: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (frm_valid_i && frm_i.port != 2'h3 && port_ctl_o[frm_i.port].egress_type == 2'b00)
      |=> (act_o.strip == ($past(frm_i.kind) == etr_pkg::ETR_HOST_TAG) && !act_o.insert))
    else $error("pass type action wrong");

  chk_strip_all: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (frm_valid_i && frm_i.port != 2'h3 && port_ctl_o[frm_i.port].egress_type == 2'b01
      && frm_i.kind != etr_pkg::ETR_UNTAGGED) |=> act_o.strip)
    else $error("tag not stripped");

  chk_src_tag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (frm_valid_i && frm_i.port != 2'h3 && port_ctl_o[frm_i.port].egress_type == 2'b11)
      |=> (act_valid_o && act_o.src_tag && !act_o.strip))
    else $error("source tag missing");

  chk_vid_gate: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (frm_valid_i && frm_i.kind == etr_pkg::ETR_REG_TAG && frm_i.port != 2'h3
      && !port_ctl_o[frm_i.port].tag_change_enable) |=> !act_o.vid_new && !act_o.prio_new)
    else $error("change without change-tag enable");

  chk_write_answer: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (aw_hold_ff && w_hold_ff && !bvalid_ff) |=> s_axi_bvalid)
    else $error("write not answered next cycle");

endmodule : etr_top
`default_nettype wire
